// >>> core/hdid_regs.svh
// register offsets, field layouts, reset values and fixed codes for the descriptor id bank
`ifndef HDID_REGS_SVH
`define HDID_REGS_SVH
`define HDID_UUID_BASE 8'h10
`define HDID_UUID_LAST 8'h1f
`define HDID_UUID_BYTES 16
`define HDID_LANG_LO_OFS 8'h20
`define HDID_LANG_HI_OFS 8'h21
`define HDID_SER_LEN_OFS 8'h22
`define HDID_MFG_LEN_OFS 8'h23
`define HDID_LANG_LO_RST 8'h09
`define HDID_LANG_HI_RST 8'h04
`define HDID_SER_LEN_RST 6'h18
`define HDID_MFG_LEN_RST 7'h00
`define HDID_SER_LEN_W 6
`define HDID_MFG_LEN_W 7
`define HDID_MFG_STR_INDEX 8'h03
`define HDID_STR0_LEN 8'h04
`define HDID_UUID_VER_BYTE 6
`define HDID_UUID_VER_CODE 4'h4
`define HDID_UUID_VAR_BYTE 8
`define HDID_UUID_VAR_CODE 2'h2
`endif

// >>> core/hdid_pkg.sv
// types shared by the descriptor id register bank
package hdid_pkg;
   typedef logic [7:0] hdid_byte_t;
   typedef logic [127:0] hdid_uuid_t;
   typedef enum logic [2:0] {
      HDID_SEL_NONE,
      HDID_SEL_UUID,
      HDID_SEL_LANG_LO,
      HDID_SEL_LANG_HI,
      HDID_SEL_SER_LEN,
      HDID_SEL_MFG_LEN
   } hdid_sel_t;
endpackage

// >>> core/hdid_bank.sv
// descriptor id register bank: uuid, language id and string lengths of the hub
// Summary of operation
// - sixteen read-only uuid bytes at 10h-1Fh form the container id identifier
// - device supplies the uuid and forces its version and variant fields
// - language low byte resets to 09h and is the code's low byte
// - language high byte resets to 04h and is the code's high byte
// - string index 0 carries exactly one language id
// - with custom text enabled, language and length fields accept overwrites
// - manufacturer length zero, the reset value, means no manufacturer string
// - nonzero manufacturer length returns that many bytes at string index 3
// - reserved length bits are read-only and read as zero
`timescale 1ns/1ps
`include "hdid_regs.svh"

module hdid_bank
(
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   // device-loaded identity and mode
   input wire hdid_pkg::hdid_uuid_t uuid_seed_in,
   input wire logic custom_text_enable_in,
   // register port, eeprom loader or smbus host
   input wire logic wr_en_in,
   input wire logic rd_en_in,
   input wire hdid_pkg::hdid_byte_t addr_in,
   input wire hdid_pkg::hdid_byte_t wr_data_in,
   output logic [7:0] rd_data_out,
   output logic rd_valid_out,
   // descriptor values toward the usb hub core
   output logic [127:0] container_id_out,
   output logic [15:0] language_code_out,
   output logic [7:0] string0_length_out,
   output logic [5:0] serial_text_length_out,
   output logic [6:0] maker_text_length_out,
   output logic maker_text_present_out,
   output logic [7:0] maker_text_index_out,
   output logic uuid_ready_out
);
   import hdid_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // address decode, used by both write and read paths
   function automatic hdid_sel_t decode(input hdid_byte_t a);
      hdid_sel_t s;
      s = HDID_SEL_NONE;
      if (a >= `HDID_UUID_BASE && a <= `HDID_UUID_LAST)
         s = HDID_SEL_UUID;
      else if (a == `HDID_LANG_LO_OFS)
         s = HDID_SEL_LANG_LO;
      else if (a == `HDID_LANG_HI_OFS)
         s = HDID_SEL_LANG_HI;
      else if (a == `HDID_SER_LEN_OFS)
         s = HDID_SEL_SER_LEN;
      else if (a == `HDID_MFG_LEN_OFS)
         s = HDID_SEL_MFG_LEN;
      return s;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // uuid capture: the seed is a level sampled once after reset release,
   // never loaded by the asynchronous reset itself
   hdid_byte_t uuid_r [`HDID_UUID_BYTES];
   hdid_byte_t uuid_nxt [`HDID_UUID_BYTES];
   logic uuid_loaded_r;
   logic uuid_loaded_nxt;

   always_comb
   begin
      uuid_loaded_nxt = 1'b1;
      for (int i = 0; i < `HDID_UUID_BYTES; i++)
      begin
         uuid_nxt[i] = uuid_r[i];
         if (!uuid_loaded_r)
            uuid_nxt[i] = uuid_seed_in[i*8 +: 8];
      end
      if (!uuid_loaded_r)
      begin
         // version 4 and rfc variant so the id keeps the urn format whatever the seed
         uuid_nxt[`HDID_UUID_VER_BYTE][7:4] = `HDID_UUID_VER_CODE;
         uuid_nxt[`HDID_UUID_VAR_BYTE][7:6] = `HDID_UUID_VAR_CODE;
      end
   end

   genvar g;
   generate
      for (g = 0; g < `HDID_UUID_BYTES; g++)
      begin : g_uuid
         always_ff @(posedge sys_clk_in or negedge rstn_in)
         begin
            if (!rstn_in)
               uuid_r[g] <= 8'h00;
            else
               uuid_r[g] <= uuid_nxt[g];
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // writable fields; stored values persist, but only count while custom text is on
   hdid_byte_t lang_lo_r, lang_lo_nxt;
   hdid_byte_t lang_hi_r, lang_hi_nxt;
   logic [`HDID_SER_LEN_W-1:0] ser_len_r, ser_len_nxt;
   logic [`HDID_MFG_LEN_W-1:0] mfg_len_r, mfg_len_nxt;
   hdid_sel_t wsel;

   always_comb
   begin
      wsel = decode(addr_in);
      lang_lo_nxt = lang_lo_r;
      lang_hi_nxt = lang_hi_r;
      ser_len_nxt = ser_len_r;
      mfg_len_nxt = mfg_len_r;
      if (wr_en_in && custom_text_enable_in)
      begin
         case (wsel)
            HDID_SEL_LANG_LO: lang_lo_nxt = wr_data_in;
            HDID_SEL_LANG_HI: lang_hi_nxt = wr_data_in;
            // reserved upper bits are dropped so they stay zero
            HDID_SEL_SER_LEN: ser_len_nxt = wr_data_in[`HDID_SER_LEN_W-1:0];
            // lengths above 64 are the writer's fault and are stored as given
            HDID_SEL_MFG_LEN: mfg_len_nxt = wr_data_in[`HDID_MFG_LEN_W-1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         lang_lo_r <= `HDID_LANG_LO_RST;
         lang_hi_r <= `HDID_LANG_HI_RST;
         ser_len_r <= `HDID_SER_LEN_RST;
         mfg_len_r <= `HDID_MFG_LEN_RST;
      end
      else
      begin
         lang_lo_r <= lang_lo_nxt;
         lang_hi_r <= lang_hi_nxt;
         ser_len_r <= ser_len_nxt;
         mfg_len_r <= mfg_len_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // effective values: defaults whenever custom text is off
   hdid_byte_t eff_lang_lo, eff_lang_hi;
   logic [`HDID_SER_LEN_W-1:0] eff_ser_len;
   logic [`HDID_MFG_LEN_W-1:0] eff_mfg_len;

   always_comb
   begin
      eff_lang_lo = custom_text_enable_in ? lang_lo_r : `HDID_LANG_LO_RST;
      eff_lang_hi = custom_text_enable_in ? lang_hi_r : `HDID_LANG_HI_RST;
      eff_ser_len = custom_text_enable_in ? ser_len_r : `HDID_SER_LEN_RST;
      eff_mfg_len = custom_text_enable_in ? mfg_len_r : `HDID_MFG_LEN_RST;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read port and descriptor outputs, all registered
   hdid_byte_t rd_data_nxt;
   logic rd_valid_nxt;
   logic [127:0] cid_nxt;
   hdid_sel_t rsel;

   always_comb
   begin
      rsel = decode(addr_in);
      rd_valid_nxt = rd_en_in;
      rd_data_nxt = 8'h00;
      case (rsel)
         HDID_SEL_UUID: rd_data_nxt = uuid_r[addr_in[3:0]];
         HDID_SEL_LANG_LO: rd_data_nxt = eff_lang_lo;
         HDID_SEL_LANG_HI: rd_data_nxt = eff_lang_hi;
         HDID_SEL_SER_LEN: rd_data_nxt = {2'h0, eff_ser_len};
         HDID_SEL_MFG_LEN: rd_data_nxt = {1'h0, eff_mfg_len};
         default: rd_data_nxt = 8'h00;
      endcase
      if (!rd_en_in)
         rd_data_nxt = rd_data_out;
      for (int i = 0; i < `HDID_UUID_BYTES; i++)
         cid_nxt[i*8 +: 8] = uuid_r[i];
   end

   always_ff @(posedge sys_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         rd_data_out <= 8'h00;
         rd_valid_out <= 1'b0;
         container_id_out <= 128'h0;
         language_code_out <= {`HDID_LANG_HI_RST, `HDID_LANG_LO_RST};
         string0_length_out <= `HDID_STR0_LEN;
         serial_text_length_out <= `HDID_SER_LEN_RST;
         maker_text_length_out <= `HDID_MFG_LEN_RST;
         maker_text_present_out <= 1'b0;
         maker_text_index_out <= 8'h00;
         uuid_ready_out <= 1'b0;
      end
      else
      begin
         rd_data_out <= rd_data_nxt;
         rd_valid_out <= rd_valid_nxt;
         container_id_out <= cid_nxt;
         language_code_out <= {eff_lang_hi, eff_lang_lo};
         // two header bytes plus a single two-byte code: one language only
         string0_length_out <= `HDID_STR0_LEN;
         serial_text_length_out <= eff_ser_len;
         maker_text_length_out <= eff_mfg_len;
         maker_text_present_out <= (eff_mfg_len != `HDID_MFG_LEN_RST);
         maker_text_index_out <= (eff_mfg_len != `HDID_MFG_LEN_RST) ?
                                 `HDID_MFG_STR_INDEX : 8'h00;
         uuid_ready_out <= uuid_loaded_r;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         uuid_loaded_r <= 1'b0;
      else
         uuid_loaded_r <= uuid_loaded_nxt;
   end

endmodule // hdid_bank

// >>> verif/hdid_bank_assertions.sv
// checker for the descriptor id register bank
`timescale 1ns/1ps
module hdid_bank_chk
(
   // watched ports
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   input wire logic custom_text_enable_in,
   input wire logic wr_en_in,
   input wire logic rd_en_in,
   input wire hdid_pkg::hdid_byte_t addr_in,
   input wire hdid_pkg::hdid_byte_t wr_data_in,
   input wire logic [7:0] rd_data_out,
   input wire logic rd_valid_out,
   input wire logic [127:0] container_id_out,
   input wire logic [15:0] language_code_out,
   input wire logic [7:0] string0_length_out,
   input wire logic [5:0] serial_text_length_out,
   input wire logic [6:0] maker_text_length_out,
   input wire logic maker_text_present_out,
   input wire logic [7:0] maker_text_index_out,
   input wire logic uuid_ready_out
);
   import hdid_pkg::*;
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rstn_in);
   ////////////////////////////////////////////////////////////////////////////////
   property p_str0; string0_length_out == 8'h04; endproperty
   a_str0: assert property (p_str0) else $error("string 0 length wrong");
   property p_pres; maker_text_present_out == (maker_text_length_out != 7'h00); endproperty
   a_pres: assert property (p_pres) else $error("maker present wrong");
   property p_idx; maker_text_index_out == (maker_text_present_out ? 8'h03 : 8'h00); endproperty
   a_idx: assert property (p_idx) else $error("maker index wrong");
   property p_rsv;
      rd_en_in && addr_in[7:1] == 7'h11 |=>
         !rd_data_out[7] && ($past(addr_in[0]) || !rd_data_out[6]);
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bit set");
   property p_lo;
      rd_en_in && !custom_text_enable_in && addr_in == 8'h20 |=> rd_data_out == 8'h09;
   endproperty
   a_lo: assert property (p_lo) else $error("language low wrong");
   property p_hi;
      rd_en_in && !custom_text_enable_in && addr_in == 8'h21 |=> rd_data_out == 8'h04;
   endproperty
   a_hi: assert property (p_hi) else $error("language high wrong");
   property p_def;
      !custom_text_enable_in |=> language_code_out == 16'h0409 &&
         serial_text_length_out == 6'h18 && maker_text_length_out == 7'h00;
   endproperty
   a_def: assert property (p_def) else $error("defaults not shown");
   // the enable must hold for the two cycles the value takes to reach the output
   property p_wr;
      custom_text_enable_in && wr_en_in && addr_in == 8'h23 ##1
         custom_text_enable_in && !wr_en_in |=>
         maker_text_length_out == $past(wr_data_in[6:0], 2);
   endproperty
   a_wr: assert property (p_wr) else $error("maker length not taken");
   property p_ver;
      uuid_ready_out |-> container_id_out[55:52] == 4'h4 && container_id_out[71:70] == 2'h2;
   endproperty
   a_ver: assert property (p_ver) else $error("uuid format wrong");
   // each read strobe gets exactly one valid pulse, on the following edge
   property p_rvld;
      rd_valid_out == $past(rd_en_in);
   endproperty
   a_rvld: assert property (p_rvld) else $error("read valid pulse wrong");
   c_wr: cover property (custom_text_enable_in && wr_en_in);
   c_pres: cover property (maker_text_present_out);
   c_uuid: cover property (rd_en_in && addr_in == 8'h16 && uuid_ready_out);
endmodule // hdid_bank_chk
bind hdid_bank hdid_bank_chk hdid_bank_chk_i (.sys_clk_in, .rstn_in, .custom_text_enable_in,
   .wr_en_in, .rd_en_in, .addr_in, .wr_data_in, .rd_data_out, .rd_valid_out,
   .container_id_out, .language_code_out, .string0_length_out, .serial_text_length_out,
   .maker_text_length_out, .maker_text_present_out, .maker_text_index_out, .uuid_ready_out);

// >>> verif/hdid_host.sv
// configuring host model: eeprom loader or smbus host on the register port
`timescale 1ns/1ps
module hdid_host
(
   // clock
   input wire logic sys_clk_in,
   // register port
   input wire logic [7:0] rd_data_in,
   output hdid_pkg::hdid_byte_t addr_out,
   output hdid_pkg::hdid_byte_t wr_data_out,
   output logic wr_en_out,
   output logic rd_en_out
);
   import hdid_pkg::*;
   initial
   begin
      {wr_en_out, rd_en_out, addr_out, wr_data_out} = '0;
   end
   // released lines show the inverse so stale values cannot pass for answers
   task wr(input hdid_byte_t a, input hdid_byte_t d);
      @(posedge sys_clk_in);
      #1 wr_en_out = 1'b1;
      addr_out = a;
      wr_data_out = (a == 8'h23 && d[6:0] > 7'h40) ? 8'h40 : d;
      @(posedge sys_clk_in);
      #1 wr_en_out = 1'b0;
      addr_out = ~a;
      wr_data_out = ~wr_data_out;
   endtask
   task rd(input hdid_byte_t a, output hdid_byte_t q);
      @(posedge sys_clk_in);
      #1 rd_en_out = 1'b1;
      addr_out = a;
      @(posedge sys_clk_in);
      #1 rd_en_out = 1'b0;
      addr_out = ~a;
      q = rd_data_in;
   endtask
endmodule // hdid_host

// >>> verif/hdid_bank_tb.sv
// self-checking bench for the descriptor id register bank
`timescale 1ns/1ps
module hdid_bank_tb;
   import hdid_pkg::*;
   typedef struct {logic c; hdid_byte_t a; hdid_byte_t d; hdid_byte_t e;} hdid_row_t;
   logic sys_clk_in, rstn_in, custom_text_enable_in, wr_en_in, rd_en_in, rd_valid_out;
   logic maker_text_present_out, uuid_ready_out;
   hdid_byte_t addr_in, wr_data_in, q;
   hdid_uuid_t uuid_seed_in = '1;
   logic [7:0] rd_data_out, string0_length_out, maker_text_index_out;
   logic [127:0] container_id_out;
   logic [15:0] language_code_out;
   logic [5:0] serial_text_length_out;
   logic [6:0] maker_text_length_out;
   int err_total, n_compared;
   hdid_row_t rows [12] = '{'{1'b1, 8'h20, 8'h5a, 8'h5a}, '{1'b1, 8'h21, 8'ha5, 8'ha5},
      '{1'b1, 8'h22, 8'hff, 8'h3f}, '{1'b1, 8'h23, 8'hc0, 8'h40}, '{1'b1, 8'h10, 8'h00, 8'hff},
      '{1'b1, 8'h16, 8'h00, 8'h4f}, '{1'b1, 8'h18, 8'h00, 8'hbf}, '{1'b1, 8'h30, 8'hff, 8'h00},
      '{1'b0, 8'h20, 8'h11, 8'h09}, '{1'b0, 8'h21, 8'h11, 8'h04}, '{1'b0, 8'h22, 8'h11, 8'h18},
      '{1'b0, 8'h23, 8'h11, 8'h00}};
   hdid_bank hdid_bank_i (.sys_clk_in, .rstn_in, .uuid_seed_in, .custom_text_enable_in,
      .wr_en_in, .rd_en_in, .addr_in, .wr_data_in, .rd_data_out, .rd_valid_out,
      .container_id_out, .language_code_out, .string0_length_out, .serial_text_length_out,
      .maker_text_length_out, .maker_text_present_out, .maker_text_index_out, .uuid_ready_out);
   hdid_host hdid_host_i (.sys_clk_in, .rd_data_in(rd_data_out), .addr_out(addr_in),
      .wr_data_out(wr_data_in), .wr_en_out(wr_en_in), .rd_en_out(rd_en_in));
   ////////////////////////////////////////////////////////////////////////////////
   task chk(input logic [127:0] g, input logic [127:0] e);
      n_compared++;
      if (g !== e)
      begin
         err_total++;
         $display("unexpected at %0t: got %0h want %0h", $time, g, e);
      end
   endtask
   task close_out;
      if (err_total == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task rst_chk;
      chk({rd_valid_out, uuid_ready_out, maker_text_length_out}, 9'h000);
      chk({language_code_out, serial_text_length_out}, 22'h010258);
   endtask
   initial
   begin
      sys_clk_in = 1'b0;
      forever #10 sys_clk_in = ~sys_clk_in;
   end
   initial
   begin
      #100000 err_total++;
      close_out();
   end
   initial
   begin
      rstn_in = 1'b0;
      custom_text_enable_in = 1'b1;
      repeat (10) @(posedge sys_clk_in);
      rst_chk();
      #1 rstn_in = 1'b1;
      repeat (3) @(posedge sys_clk_in);
      #1;
      chk(uuid_ready_out, 1'b1);
      chk(container_id_out, 128'hffffffffffffffbfff4fffffffffffff);
      foreach (rows[i])
      begin
         custom_text_enable_in = rows[i].c;
         hdid_host_i.wr(rows[i].a, rows[i].d);
         hdid_host_i.rd(rows[i].a, q);
         chk(q, rows[i].e);
      end
      // stored custom values come back once the enable returns
      custom_text_enable_in = 1'b1;
      repeat (3) @(posedge sys_clk_in);
      #1;
      chk({language_code_out, serial_text_length_out}, 22'h2956bf);
      chk({maker_text_present_out, maker_text_index_out}, 9'h103);
      chk(string0_length_out, 8'h04);
      hdid_host_i.wr(8'h23, 8'h00);
      repeat (2) @(posedge sys_clk_in);
      #1;
      chk({maker_text_present_out, maker_text_index_out}, 9'h000);
      // mid-run reset: the uuid must be captured again after release
      rstn_in = 1'b0;
      #1 rst_chk();
      @(posedge sys_clk_in);
      #1 rstn_in = 1'b1;
      repeat (3) @(posedge sys_clk_in);
      #1;
      chk(language_code_out, 16'h0409);
      chk(uuid_ready_out, 1'b1);
      chk(container_id_out, 128'hffffffffffffffbfff4fffffffffffff);
      close_out();
   end
endmodule // hdid_bank_tb
